// *** common/dcwl_pkg.sv ***
// shared constants and types for the control word loader
package dcwl_pkg;

  // ==========================================================
  // word layout
  localparam int WORD_W = 40;
  localparam int FREQ_W = 32;
  localparam int PHASE_W = 5;
  localparam int BYTE_W = 8;
  localparam int NUM_BYTES = 5;
  localparam int CTL_LSB = 32;
  localparam int MULT_BIT = 32;
  localparam int TEST_BIT = 33;
  localparam int PD_BIT = 34;
  localparam int PHASE_LSB = 35;
  localparam int SERIAL_DATA_BIT = 7;
  localparam logic [2:0] SERIAL_ENTRY_CODE = 3'h3;
  localparam logic [WORD_W-1:0] HOLD_RESET = 40'h00_0000_0000;

  // ==========================================================
  // byte pointer
  localparam logic [2:0] PTR_FIRST = 3'h0;
  localparam logic [2:0] PTR_FULL = 3'h5;

  // ==========================================================
  // timing in core clock cycles
  localparam int FREQ_LATENCY_CYC = 18;
  localparam int PHASE_LATENCY_CYC = 13;

  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_HOLD_FREQ = 8'h08;
  localparam logic [7:0] REG_HOLD_CTRL = 8'h0C;
  localparam logic [7:0] REG_ACT_FREQ = 8'h10;
  localparam logic [7:0] REG_ACT_CTRL = 8'h14;
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int CTRL_SOFT_UPDATE_BIT = 1;
  localparam int ST_PTR_LSB = 0;
  localparam int ST_SERIAL_BIT = 3;
  localparam int ST_PD_BIT = 4;
  localparam int ST_MULT_BIT = 5;
  localparam int ST_TEST_BIT = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // load format
  typedef enum logic [0:0] {
    MODE_PARALLEL = 1'b0,
    MODE_SERIAL = 1'b1
  } dcwl_mode_t;

endpackage

// *** core/dcwl_delay_line.sv ***
// fixed latency delay line carrying a valid flag and a data word
`timescale 1ns/1ns
`default_nettype none
module dcwl_delay_line #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear,
  // entry side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  // exit side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);

  // ==========================================================
  // stages
  logic [DEPTH:0] vld;
  logic [WIDTH-1:0] dat [DEPTH:0];

  assign vld[0] = in_valid;
  assign dat[0] = in_data;

  genvar g;
  generate
    for (g = 1; g <= DEPTH; g++) begin : g_stage
      // clear drops every pending word so a reset cannot be undone later
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          vld[g] <= 1'b0;
          dat[g] <= '0;
        end else if (clear) begin
          vld[g] <= 1'b0;
          dat[g] <= '0;
        end else begin
          vld[g] <= vld[g-1];
          dat[g] <= dat[g-1];
        end
      end
    end
  endgenerate

  assign out_valid = vld[DEPTH];
  assign out_data = dat[DEPTH];

endmodule
`default_nettype wire

// *** core/dcwl_top.sv ***
// control word loader: byte and serial loading, update, master reset
// ==========================================================
// How it works
// R1 - parallel word is five bytes: control first, then frequency MSB to LSB
// R2 - control byte: phase on bits 7..3, power-down 2, test 1, multiplier 0
// R3 - host keeps test bit zero except to request serial mode
// R4 - after serial entry host keeps test bit zero in every word
// R5 - serial stream starts at frequency LSB, ends at control byte MSB
// R6 - serial bits 0..31 frequency, then multiplier, test, power-down, phase
// R7 - one control byte plus update strobe changes control only
// R8 - bytes load in sequence; host reloads from control byte up to target
// R9 - new frequency shows 18 cycles after update, phase after 13
// R10 - master reset zeroes the phase accumulator
// R11 - master reset zeroes the active phase offset
// R12 - master reset returns byte pointer to the control byte
// R13 - master reset clears power-down
// R14 - master reset leaves the holding register untouched
// R15 - master reset disables multiplier and selects parallel loading
// R16 - master reset may arrive asynchronously to the core clock
// R17 - serial mode entered from parallel by control low bits 011 and update
// R18 - entry byte may come over the bus or by fixed wiring
// R19 - host should load a valid serial word and update after entry
// R20 - valid serial word has test bit, position 33, at zero
// R21 - update rising edge transfers holding word and resets pointer
// R22 - each parallel load edge takes a byte; after five, edges ignored
// R23 - each serial load edge shifts in data line bit 7
// R24 - serial mode left only by master reset
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module dcwl_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // host load pins
  input wire logic word_load_clock,
  input wire logic update_strobe,
  input wire logic [7:0] load_data,
  input wire logic master_reset,
  // synthesis core
  output logic [31:0] tuning_word,
  output logic [4:0] phase_offset,
  output logic power_down,
  output logic ref_mult_enable,
  output logic serial_mode,
  output logic test_mode,
  output logic [31:0] phase_acc,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // reset release
  logic [1:0] rst_sync_q;
  logic rst_sync_n;

  // release through two flops, assert at once
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_q[1];

  // ==========================================================
  // pin synchronisers
  logic [10:0] pin_s1_q;
  logic [10:0] pin_s2_q;
  logic wclk_s3_q;
  logic upd_s3_q;
  logic [7:0] data_s;
  logic wclk_rise;
  logic upd_pin_rise;
  logic mrst_pin;

  // R16 - async reset pin caught by two flops like every other pin
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_s1_q <= 11'h000;
      pin_s2_q <= 11'h000;
      wclk_s3_q <= 1'b0;
      upd_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= {master_reset, update_strobe, word_load_clock, load_data};
      pin_s2_q <= pin_s1_q;
      wclk_s3_q <= pin_s2_q[8];
      upd_s3_q <= pin_s2_q[9];
    end
  end
  // data shares the sync depth of the load clock, so it is aligned at edges
  assign data_s = pin_s2_q[7:0];
  assign wclk_rise = pin_s2_q[8] & ~wclk_s3_q;
  assign upd_pin_rise = pin_s2_q[9] & ~upd_s3_q;
  assign mrst_pin = pin_s2_q[10];

  // ==========================================================
  // event qualification
  logic soft_reset_q;
  logic soft_update_q;
  logic mrst_fire;
  logic upd_fire;
  logic load_fire;

  // master reset beats update, update beats a load edge
  assign mrst_fire = mrst_pin | soft_reset_q;
  assign upd_fire = (upd_pin_rise | soft_update_q) & ~mrst_fire;
  assign load_fire = wclk_rise & ~mrst_fire & ~upd_fire;

  // ==========================================================
  // mode, pointer and holding register
  dcwl_pkg::dcwl_mode_t mode_q;
  logic [2:0] ptr_q;
  logic [39:0] hold_q;
  logic [39:0] hold_d;
  logic [4:0] byte_sel;
  logic serial_entry;

  assign serial_mode = (mode_q == dcwl_pkg::MODE_SERIAL);

  // R17 - entry only from parallel with low control bits 011
  assign serial_entry = upd_fire && !serial_mode &&
    (hold_q[dcwl_pkg::CTL_LSB +: 3] == dcwl_pkg::SERIAL_ENTRY_CODE);

  // R15 - reset selects parallel; R24 - nothing else leaves serial
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_q <= dcwl_pkg::MODE_PARALLEL;
    end else if (mrst_fire) begin
      mode_q <= dcwl_pkg::MODE_PARALLEL;
    end else if (serial_entry) begin
      mode_q <= dcwl_pkg::MODE_SERIAL;
    end
  end

  // R12 - reset and R21 - update rewind; R22 - advance until full
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ptr_q <= dcwl_pkg::PTR_FIRST;
    end else if (mrst_fire || upd_fire) begin
      ptr_q <= dcwl_pkg::PTR_FIRST;
    end else if (load_fire && !serial_mode &&
        ptr_q != dcwl_pkg::PTR_FULL) begin
      ptr_q <= ptr_q + 3'h1;
    end
  end

  // one select per byte slot; slot 0 is the control byte
  genvar g;
  generate
    for (g = 0; g < dcwl_pkg::NUM_BYTES; g++) begin : g_sel
      assign byte_sel[g] = (ptr_q == 3'(g));
    end
  endgenerate

  // next holding word; mode decides byte placement or shift
  always_comb begin
    hold_d = hold_q;
    if (load_fire) begin
      case (mode_q)
        dcwl_pkg::MODE_SERIAL: begin
          // R23 - shift in bit 7; R5 R6 - first bit lands at position 0
          hold_d = {data_s[dcwl_pkg::SERIAL_DATA_BIT], hold_q[39:1]};
        end
        default: begin
          // R1 R2 - slot k fills bits 39-8k down; full pointer selects none
          for (int k = 0; k < dcwl_pkg::NUM_BYTES; k++) begin
            if (byte_sel[k]) begin
              hold_d[dcwl_pkg::WORD_W-1-dcwl_pkg::BYTE_W*k -: 8] = data_s;
            end
          end
        end
      endcase
    end
  end

  // R14 - master reset is absent here, the word survives it
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hold_q <= dcwl_pkg::HOLD_RESET;
    end else begin
      hold_q <= hold_d;
    end
  end

  // ==========================================================
  // transfer to the core
  logic freq_vld;
  logic [31:0] freq_dat;
  logic ph_vld;
  logic [4:0] ph_dat;

  // R9 - one stage short, the active register adds the last cycle
  dcwl_delay_line #(
    .WIDTH(dcwl_pkg::FREQ_W),
    .DEPTH(dcwl_pkg::FREQ_LATENCY_CYC - 1)
  ) u_freq_delay (
    .clock(clock),
    .rst_n(rst_sync_n),
    .clear(mrst_fire),
    .in_valid(upd_fire),
    .in_data(hold_q[31:0]),
    .out_valid(freq_vld),
    .out_data(freq_dat)
  );

  dcwl_delay_line #(
    .WIDTH(dcwl_pkg::PHASE_W),
    .DEPTH(dcwl_pkg::PHASE_LATENCY_CYC - 1)
  ) u_phase_delay (
    .clock(clock),
    .rst_n(rst_sync_n),
    .clear(mrst_fire),
    .in_valid(upd_fire),
    .in_data(hold_q[dcwl_pkg::PHASE_LSB +: 5]),
    .out_valid(ph_vld),
    .out_data(ph_dat)
  );

  // R10 - frequency cleared too, so the output stays at dc
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tuning_word <= 32'h0000_0000;
    end else if (mrst_fire) begin
      tuning_word <= 32'h0000_0000;
    end else if (freq_vld) begin
      tuning_word <= freq_dat;
    end
  end

  // R11 - phase offset zero after master reset
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase_offset <= 5'h00;
    end else if (mrst_fire) begin
      phase_offset <= 5'h00;
    end else if (ph_vld) begin
      phase_offset <= ph_dat;
    end
  end

  // R13 R15 - control flags cleared; R7 R21 - update applies control byte
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      power_down <= 1'b0;
      ref_mult_enable <= 1'b0;
      test_mode <= 1'b0;
    end else if (mrst_fire) begin
      power_down <= 1'b0;
      ref_mult_enable <= 1'b0;
      test_mode <= 1'b0;
    end else if (upd_fire) begin
      power_down <= hold_q[dcwl_pkg::PD_BIT];
      ref_mult_enable <= hold_q[dcwl_pkg::MULT_BIT];
      // the entry word itself carries the test bit but is not a test request
      test_mode <= hold_q[dcwl_pkg::TEST_BIT] & ~serial_entry;
    end
  end

  // R10 - accumulator held at zero while reset stands; frozen in power-down
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase_acc <= 32'h0000_0000;
    end else if (mrst_fire) begin
      phase_acc <= 32'h0000_0000;
    end else if (!power_down) begin
      phase_acc <= phase_acc + tuning_word;
    end
  end

  // ==========================================================
  // axi4-lite slave
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic wr_ctrl;
  logic [31:0] rd_word;
  logic rd_hit;

  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_ctrl = do_write && awaddr_q == dcwl_pkg::REG_CTRL && wstrb_q[0];

  // address and data are parked separately, taken in either order
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response; only the control register accepts writes
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dcwl_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_q == dcwl_pkg::REG_CTRL) ?
        dcwl_pkg::RESP_OKAY : dcwl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control bits are self-clearing one-cycle commands
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      soft_reset_q <= 1'b0;
      soft_update_q <= 1'b0;
    end else begin
      soft_reset_q <= wr_ctrl & wdata_q[dcwl_pkg::CTRL_SOFT_RESET_BIT];
      soft_update_q <= wr_ctrl & wdata_q[dcwl_pkg::CTRL_SOFT_UPDATE_BIT];
    end
  end

  // read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == dcwl_pkg::REG_CTRL) begin
      rd_word = 32'h0000_0000;
    end else if (s_axi_araddr == dcwl_pkg::REG_STATUS) begin
      rd_word[dcwl_pkg::ST_PTR_LSB +: 3] = ptr_q;
      rd_word[dcwl_pkg::ST_SERIAL_BIT] = serial_mode;
      rd_word[dcwl_pkg::ST_PD_BIT] = power_down;
      rd_word[dcwl_pkg::ST_MULT_BIT] = ref_mult_enable;
      rd_word[dcwl_pkg::ST_TEST_BIT] = test_mode;
    end else if (s_axi_araddr == dcwl_pkg::REG_HOLD_FREQ) begin
      rd_word = hold_q[31:0];
    end else if (s_axi_araddr == dcwl_pkg::REG_HOLD_CTRL) begin
      rd_word[7:0] = hold_q[39:32];
    end else if (s_axi_araddr == dcwl_pkg::REG_ACT_FREQ) begin
      rd_word = tuning_word;
    end else if (s_axi_araddr == dcwl_pkg::REG_ACT_CTRL) begin
      rd_word[7:0] = {phase_offset, power_down, test_mode, ref_mult_enable};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dcwl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? dcwl_pkg::RESP_OKAY : dcwl_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  logic [4:0] since_upd_q;
  logic [31:0] exp_freq_q;
  logic [4:0] exp_phase_q;

  // age of the newest update and the word it carried
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      since_upd_q <= 5'h00;
      exp_freq_q <= 32'h0000_0000;
      exp_phase_q <= 5'h00;
    end else if (mrst_fire) begin
      since_upd_q <= 5'h00;
    end else if (upd_fire) begin
      since_upd_q <= 5'h01;
      exp_freq_q <= hold_q[31:0];
      exp_phase_q <= hold_q[dcwl_pkg::PHASE_LSB +: 5];
    end else if (since_upd_q != 5'h00 && since_upd_q != 5'h1F) begin
      since_upd_q <= since_upd_q + 5'h01;
    end
  end

  freq_latency_a: assert property ( // R9
    since_upd_q == 5'd18 |-> tuning_word == exp_freq_q)
    else $error("frequency not applied 18 cycles after update");
  phase_latency_a: assert property ( // R9
    since_upd_q == 5'd13 |-> phase_offset == exp_phase_q &&
      $past(phase_offset) == $past(phase_offset, 2))
    else $error("phase not applied 13 cycles after update");
  reset_clears_a: assert property ( // R10
    mrst_fire |=> phase_acc == 32'h0 && phase_offset == 5'h0 &&
      ptr_q == 3'h0 && !power_down && !ref_mult_enable && !serial_mode)
    else $error("master reset left state behind");
  reset_keeps_hold_a: assert property ( // R14
    mrst_fire |=> hold_q == $past(hold_q))
    else $error("master reset changed holding word");
  update_rewind_a: assert property ( // R21
    upd_fire |=> ptr_q == 3'h0 && power_down == $past(hold_q[34]))
    else $error("update did not rewind pointer or apply control");
  byte_advance_a: assert property ( // R22
    load_fire && !serial_mode && ptr_q == 3'h1 |=>
      ptr_q == 3'h2 && hold_q[31:24] == $past(data_s))
    else $error("second byte not taken as frequency high byte");
  full_ignore_a: assert property ( // R22
    load_fire && !serial_mode && ptr_q == 3'h5 |=> $stable(hold_q))
    else $error("load edge after five bytes changed the word");
  serial_shift_a: assert property ( // R23
    load_fire && serial_mode |=>
      hold_q == {$past(data_s[7]), $past(hold_q[39:1])})
    else $error("serial edge did not shift bit 7 in at the top");
  serial_entry_a: assert property ( // R17
    serial_entry ##1 !mrst_fire[*3] |-> serial_mode)
    else $error("serial mode not entered or left without reset");

  upd_arrival_c: cover property (since_upd_q == 5'd18);
  serial_entered_c: cover property (serial_entry);
  all_bytes_c: cover property (ptr_q == 3'h5 && load_fire);
  soft_update_c: cover property (soft_update_q);

endmodule
`default_nettype wire

// *** verification/dcwl_host_model.sv ***
// host controller model that drives the load pins of the word loader
`timescale 1ns/1ns
`default_nettype none
module dcwl_host_model (
  // clock
  input wire logic clock,
  // load pins
  output logic word_load_clock,
  output logic update_strobe,
  output logic [7:0] load_data,
  output logic master_reset
);
  // ==========================================================
  // idle pin levels
  initial begin
    word_load_clock = 1'b0;
    update_strobe = 1'b0;
    load_data = 8'h00;
    master_reset = 1'b0;
  end

  // ==========================================================
  // one byte on a 400 ns load clock; data held well around the rise
  // bytes in sequence
  task automatic load_byte(input logic [7:0] b);
    @(posedge clock);
    load_data <= b;
    repeat (2) @(posedge clock);
    word_load_clock <= 1'b1;
    repeat (4) @(posedge clock);
    word_load_clock <= 1'b0;
    @(posedge clock);
    // a released bus must not keep showing the old value
    load_data <= ~b;
  endtask

  // update when upd is high, master reset otherwise
  task automatic pulse(input logic upd);
    @(posedge clock);
    if (upd) update_strobe <= 1'b1;
    else master_reset <= 1'b1;
    repeat (4) @(posedge clock);
    update_strobe <= 1'b0;
    master_reset <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task automatic serial_word(input logic [39:0] w);
    for (int i = 0; i < 40; i++) begin
      load_byte({w[i], 7'h2A});
    end
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the control word loader
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock, rst_n;
  wire logic word_load_clock, update_strobe, master_reset;
  wire logic [7:0] load_data;
  logic [31:0] tuning_word, phase_acc, s_axi_wdata, s_axi_rdata;
  logic [4:0] phase_offset;
  logic power_down, ref_mult_enable, serial_mode, test_mode;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int n_errors, checks_done;
  logic [33:0] notes[$];
  logic [31:0] seed, f, f3;
  logic [4:0] p, p3;
  logic [7:0] hi;

  dcwl_host_model i_dcwl_host_model (.clock(clock),
    .word_load_clock(word_load_clock), .update_strobe(update_strobe),
    .load_data(load_data), .master_reset(master_reset));
  dcwl_top i_dcwl_top (.clock(clock), .rst_n(rst_n),
    .word_load_clock(word_load_clock), .update_strobe(update_strobe),
    .load_data(load_data), .master_reset(master_reset),
    .tuning_word(tuning_word), .phase_offset(phase_offset),
    .power_down(power_down), .ref_mult_enable(ref_mult_enable),
    .serial_mode(serial_mode), .test_mode(test_mode), .phase_acc(phase_acc),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [33:0] e,
                       input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // one bus access; ready and valid are looked at half a cycle early
  // so the decision never races the sampling edge
  task automatic axi(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [33:0] e);
    logic ta, tw, tr, fin;
    fin = 1'b0;
    notes.push_back(e);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (!fin) begin
      @(negedge clock);
      ta = (s_axi_awvalid && s_axi_awready) ||
        (s_axi_arvalid && s_axi_arready);
      tw = s_axi_wvalid && s_axi_wready;
      tr = wr ? s_axi_bvalid : s_axi_rvalid;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (ta) s_axi_arvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_bready <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      fin = tr;
    end
  endtask

  // answers are matched against the oldest note
  always @(negedge clock) begin
    if (s_axi_rvalid && s_axi_rready && notes.size() > 0)
      check("read", notes.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready && notes.size() > 0)
      check("bresp", notes.pop_front(), {s_axi_bresp, 32'h0});
  end

  // update and measure when frequency and phase arrive at the core
  task automatic upd_timed(input logic [31:0] ef, input logic [4:0] ep,
                           input logic [33:0] lf, input logic [33:0] lp);
    logic [33:0] tf, tp;
    tf = 34'h0;
    tp = 34'h0;
    fork
      i_dcwl_host_model.pulse(1'b1);
      begin
        @(posedge clock);
        for (int k = 1; k <= 24; k++) begin
          @(negedge clock);
          if (tp == 0 && phase_offset === ep) tp = 34'(k);
          if (tf == 0 && tuning_word === ef) tf = 34'(k);
        end
      end
    join
    check("phase latency", lp, tp);
    check("freq latency", lf, tf);
  endtask

  task automatic load5(input logic [7:0] c, input logic [31:0] w);
    i_dcwl_host_model.load_byte(c);
    for (int i = 3; i >= 0; i--) i_dcwl_host_model.load_byte(w[i*8+:8]);
  endtask

  // ==========================================================
  // clock and watchdog; the run needs well under a thousand cycles
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    #500000;
    n_errors++;
    complete_run;
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    seed = 32'h63;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    seed = lfsr(lfsr(seed));
    f = seed;
    p = seed[12:8] | 5'h01;
    // five bytes plus a sixth edge that must be ignored
    load5({p, 3'h1}, f);
    i_dcwl_host_model.load_byte(8'hA5);
    axi(1'b0, dcwl_pkg::REG_HOLD_FREQ, 32'h0, {2'h0, f});
    axi(1'b0, dcwl_pkg::REG_HOLD_CTRL, 32'h0, {26'h0, p, 3'h1});
    upd_timed(f, p, 34'd21, 34'd16);
    check("mult", 34'h1, {33'h0, ref_mult_enable});
    // control byte only: power down, multiplier off
    i_dcwl_host_model.load_byte({~p, 3'h4});
    upd_timed(f, ~p, 34'd1, 34'd16);
    check("pd", 34'h1, {33'h0, power_down});
    // reload from control byte up to the high frequency byte
    hi = ~f[31:24];
    i_dcwl_host_model.load_byte({p, 3'h1});
    i_dcwl_host_model.load_byte(hi);
    upd_timed({hi, f[23:0]}, p, 34'd21, 34'd16);
    // master reset with the pointer in mid-word
    i_dcwl_host_model.load_byte(8'h00);
    i_dcwl_host_model.load_byte(8'h11);
    i_dcwl_host_model.pulse(1'b0);
    @(negedge clock);
    check("freq", 34'h0, {2'h0, tuning_word});
    check("acc", 34'h0, {2'h0, phase_acc});
    check("phase", 34'h0, {29'h0, phase_offset});
    check("flags", 34'h0,
      {31'h0, power_down, ref_mult_enable, serial_mode});
    axi(1'b0, dcwl_pkg::REG_STATUS, 32'h0, 34'h0);
    axi(1'b0, dcwl_pkg::REG_HOLD_FREQ, 32'h0, {10'h0, 8'h11, f[23:0]});
    // serial entry, then one serial word
    i_dcwl_host_model.load_byte(8'h03);
    i_dcwl_host_model.pulse(1'b1);
    @(negedge clock);
    check("serial", 34'h1, {33'h0, serial_mode});
    seed = lfsr(seed);
    f3 = seed;
    p3 = seed[20:16] | 5'h01;
    i_dcwl_host_model.serial_word({p3, 3'h0, f3});
    axi(1'b0, dcwl_pkg::REG_HOLD_FREQ, 32'h0, {2'h0, f3});
    axi(1'b0, dcwl_pkg::REG_HOLD_CTRL, 32'h0, {26'h0, p3, 3'h0});
    upd_timed(f3, p3, 34'd21, 34'd16);
    check("serial kept", 34'h1, {33'h0, serial_mode});
    // bus refusals, then soft master reset back to parallel
    axi(1'b1, dcwl_pkg::REG_HOLD_FREQ, seed, {dcwl_pkg::RESP_SLVERR, 32'h0});
    axi(1'b0, 8'h20, 32'h0, {dcwl_pkg::RESP_SLVERR, 32'h0});
    // control write with its low byte strobe off must do nothing
    s_axi_wstrb <= 4'hE;
    axi(1'b1, dcwl_pkg::REG_CTRL, 32'h3, {dcwl_pkg::RESP_OKAY, 32'h0});
    s_axi_wstrb <= 4'hF;
    axi(1'b0, dcwl_pkg::REG_ACT_FREQ, 32'h0, {2'h0, f3});
    axi(1'b1, dcwl_pkg::REG_CTRL, 32'h3, {dcwl_pkg::RESP_OKAY, 32'h0});
    repeat (4) @(negedge clock);
    check("parallel", 34'h0, {32'h0, serial_mode, ref_mult_enable});
    complete_run;
  end
endmodule
`default_nettype wire
